// ===== hw/tx_irq_pkg.sv
// Constants for the transmit DMA channel interrupt and coalescing block.
package tx_irq_pkg;

  // ==========================================================================
  // Register addresses
  // ==========================================================================
  localparam logic [9:0] CTRL_ADDR = 10'h085;
  localparam logic [9:0] IRQ_ADDR = 10'h086;

  // ==========================================================================
  // Bit positions in the stored vector (index 0 is printed bit 31)
  // ==========================================================================
  localparam int COAL_EN_POS = 0;
  localparam int DLY_EN_POS = 1;
  localparam int ERR_EN_POS = 2;
  localparam int MASTER_EN_POS = 7;
  localparam int LOAD_POS = 8;
  localparam int IOE_SEL_POS = 9;
  localparam int ONE_BIT_POS = 10;
  localparam int MSB_ADDR_LSB = 12;
  localparam int PRELOAD_LSB = 16;
  localparam int TIMEOUT_LSB = 24;

  localparam int COAL_FLAG_POS = 0;
  localparam int DLY_FLAG_POS = 1;
  localparam int ERR_FLAG_POS = 2;
  localparam int WR_FAULT_POS = 3;
  localparam int RD_FAULT_POS = 4;
  localparam int DLY_PEND_LSB = 8;
  localparam int COAL_PEND_LSB = 10;
  localparam int COAL_CNT_LSB = 16;
  localparam int DLY_TMR_LSB = 24;

  // ==========================================================================
  // Values after reset and limits
  // ==========================================================================
  localparam logic [31:0] LOAD_MASK = 32'h0000_0100;
  localparam logic [31:0] CFG_DEFAULT = 32'h0000_0000;
  localparam logic [3:0] COAL_PEND_MAX = 4'hf;
  localparam logic [3:0] DLY_PEND_MAX = 4'h3;
  localparam logic [3:0] ONE_BIT_MAX = 4'h1;
  localparam logic [3:0] PEND_RESET = 4'h0;
  localparam logic [7:0] TIMER_RESET = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage

// ===== hw/tx_dma_irq_coalescing.sv
// Interrupt control, coalescing and status logic of one transmit DMA channel.
module tx_dma_irq_coalescing
  import tx_irq_pkg::*;
#(
  // Channel configuration attribute; the default value is arbitrary.
  parameter logic [31:0] CHANNEL_CONFIG_ATTRIBUTE = CFG_DEFAULT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic soft_reset,
  input wire logic [9:0] dcr_addr,
  input wire logic dcr_read,
  input wire logic dcr_write,
  input wire logic [31:0] dcr_wdata,
  output logic [31:0] dcr_rdata,
  output logic dcr_ack,
  input wire logic eop_event,
  input wire logic ioe_event,
  input wire logic error_event,
  input wire logic bus_read_fault,
  input wire logic bus_write_fault,
  input wire logic delay_tick,
  input wire logic delay_run,
  output logic tx_irq,
  output logic stream_freeze
);

  // ==========================================================================
  // Pending counter arithmetic
  // ==========================================================================
  function automatic logic [3:0] step_pend(input logic [3:0] cur,
                                           input logic inc,
                                           input logic dec,
                                           input logic [3:0] lim);
    logic [3:0] v;
    v = cur;
    if (dec && (v != 4'h0)) begin
      v = v - 4'h1;
    end
    if (inc && (v < lim)) begin
      v = v + 4'h1;
    end
    if (v > lim) begin
      v = lim;
    end
    return v;
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  logic [31:0] ctrl_q, ctrl_d;
  logic [7:0] coal_cnt_q, coal_cnt_d;
  logic [7:0] dly_tmr_q, dly_tmr_d;
  logic [3:0] coal_pend_q, coal_pend_d;
  logic [3:0] dly_pend_q, dly_pend_d;
  logic err_q, err_d;
  logic rd_fault_q, wr_fault_q;
  logic irq_q;
  logic [31:0] rdata_q;
  logic ack_q;

  wire any_reset = !reset_n || soft_reset;

  // ==========================================================================
  // Register decode
  // ==========================================================================
  wire wr_ctrl = dcr_write && (dcr_addr == CTRL_ADDR);
  wire wr_irq = dcr_write && (dcr_addr == IRQ_ADDR);
  wire rd_ctrl = dcr_read && (dcr_addr == CTRL_ADDR);
  wire rd_irq = dcr_read && (dcr_addr == IRQ_ADDR);
  wire load_req = wr_ctrl && dcr_wdata[LOAD_POS];
  wire ack_coal = wr_irq && dcr_wdata[COAL_FLAG_POS];
  wire ack_dly = wr_irq && dcr_wdata[DLY_FLAG_POS];
  wire ack_err = wr_irq && dcr_wdata[ERR_FLAG_POS];

  // Control fields; bit positions are stored-vector indices, with index 0 the least significant bit.
  wire coal_en = ctrl_q[COAL_EN_POS];
  wire dly_en = ctrl_q[DLY_EN_POS];
  wire err_en = ctrl_q[ERR_EN_POS];
  wire master_en = ctrl_q[MASTER_EN_POS];
  wire ioe_sel = ctrl_q[IOE_SEL_POS];
  wire one_bit = ctrl_q[ONE_BIT_POS];
  wire [7:0] preload = ctrl_q[PRELOAD_LSB +: 8];
  wire [7:0] timeout = ctrl_q[TIMEOUT_LSB +: 8];
  wire [7:0] new_preload = dcr_wdata[PRELOAD_LSB +: 8];

  // The load bit is never stored, so it always reads back as zero.
  assign ctrl_d = wr_ctrl ? (dcr_wdata & ~LOAD_MASK) : ctrl_q;

  // ==========================================================================
  // Coalescing counter
  // ==========================================================================
  wire count_event = ioe_sel ? ioe_event : eop_event;
  wire coal_step = count_event && coal_en;
  wire coal_hit = coal_step && !load_req && (coal_cnt_q <= 8'h01);

  always_comb begin
    coal_cnt_d = coal_cnt_q;
    if (load_req) begin
      coal_cnt_d = new_preload;
    end else if (coal_hit) begin
      coal_cnt_d = preload;
    end else if (coal_step) begin
      coal_cnt_d = coal_cnt_q - 8'h01;
    end
  end

  // ==========================================================================
  // Delay timer
  // ==========================================================================
  // The timer restarts on every counted event and while the channel is idle.
  wire dly_match = delay_tick && delay_run && !count_event &&
                   (dly_tmr_q == timeout);
  wire dly_hit = dly_match && dly_en;

  always_comb begin
    dly_tmr_d = dly_tmr_q;
    if (count_event || !delay_run || dly_match) begin
      dly_tmr_d = TIMER_RESET;
    end else if (delay_tick) begin
      dly_tmr_d = dly_tmr_q + 8'h01;
    end
  end

  // ==========================================================================
  // Pending counters and flags
  // ==========================================================================
  wire [3:0] coal_lim = one_bit ? ONE_BIT_MAX : COAL_PEND_MAX;
  wire [3:0] dly_lim = one_bit ? ONE_BIT_MAX : DLY_PEND_MAX;

  assign coal_pend_d = step_pend(coal_pend_q, coal_hit, ack_coal,
                                 coal_lim);
  assign dly_pend_d = step_pend(dly_pend_q, dly_hit, ack_dly,
                                dly_lim);

  // A new error in the cycle of its acknowledge keeps the flag set.
  assign err_d = (error_event && err_en) || (err_q && !ack_err);

  wire coal_flag = coal_pend_q != PEND_RESET;
  wire dly_flag = dly_pend_q != PEND_RESET;
  wire irq_d = master_en &&
               ((coal_pend_d != PEND_RESET) ||
                (dly_pend_d != PEND_RESET) || err_d);

  // ==========================================================================
  // Status word
  // ==========================================================================
  logic [31:0] irq_word;
  always_comb begin
    irq_word = WORD_ZERO;
    irq_word[COAL_FLAG_POS] = coal_flag;
    irq_word[DLY_FLAG_POS] = dly_flag;
    irq_word[ERR_FLAG_POS] = err_q;
    irq_word[WR_FAULT_POS] = wr_fault_q;
    irq_word[RD_FAULT_POS] = rd_fault_q;
    irq_word[DLY_PEND_LSB +: 2] = dly_pend_q[1:0];
    irq_word[COAL_PEND_LSB +: 4] = coal_pend_q;
    irq_word[COAL_CNT_LSB +: 8] = coal_cnt_q;
    irq_word[DLY_TMR_LSB +: 8] = dly_tmr_q;
  end

  wire [31:0] rdata_d = rd_ctrl ? ctrl_q : (rd_irq ? irq_word : WORD_ZERO);

  // ==========================================================================
  // Flip-flops
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (any_reset) begin
      ctrl_q <= CHANNEL_CONFIG_ATTRIBUTE & ~LOAD_MASK;
      coal_cnt_q <= CHANNEL_CONFIG_ATTRIBUTE[PRELOAD_LSB +: 8];
      dly_tmr_q <= TIMER_RESET;
      coal_pend_q <= PEND_RESET;
      dly_pend_q <= PEND_RESET;
      err_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      coal_cnt_q <= coal_cnt_d;
      dly_tmr_q <= dly_tmr_d;
      coal_pend_q <= coal_pend_d;
      dly_pend_q <= dly_pend_d;
      err_q <= err_d;
      irq_q <= irq_d;
    end
  end

  // Fault flags ignore every write; only a reset clears them.
  always_ff @(posedge clk) begin
    if (any_reset) begin
      rd_fault_q <= 1'b0;
      wr_fault_q <= 1'b0;
    end else begin
      rd_fault_q <= rd_fault_q || bus_read_fault;
      wr_fault_q <= wr_fault_q || bus_write_fault;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_q <= WORD_ZERO;
      ack_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ack_q <= dcr_read || dcr_write;
    end
  end

  assign dcr_rdata = rdata_q;
  assign dcr_ack = ack_q;
  assign tx_irq = irq_q;
  assign stream_freeze = rd_fault_q || wr_fault_q;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (any_reset);

  a_irq_master_gate: assert property (
    !master_en && !wr_ctrl |=> !tx_irq)
    else $error("interrupt raised with master enable off");

  a_irq_source_or: assert property (
    master_en && !wr_ctrl && err_q && !ack_err |=> tx_irq)
    else $error("pending error did not raise interrupt");

  a_load_copies: assert property (
    load_req |=> (coal_cnt_q == preload) && !ctrl_q[LOAD_POS])
    else $error("load did not copy preload or did not self clear");

  a_reload_zero: assert property (
    coal_hit |=> coal_cnt_q == $past(preload))
    else $error("coalescing counter not reloaded at zero");

  a_delay_event: assert property (
    dly_hit && !ack_dly |=> dly_pend_q != PEND_RESET)
    else $error("delay match did not raise pending delay");

  a_error_disable: assert property (
    !err_en && !err_q |=> !err_q)
    else $error("error flag set while source disabled");

  a_error_ack: assert property (
    err_q && ack_err && !(error_event && err_en) |=> !err_q)
    else $error("error acknowledge did not clear flag");

  a_coal_ack_last: assert property (
    (coal_pend_q == 4'h1) && ack_coal && !coal_hit |=>
      !coal_flag ##1 (!coal_flag || $past(coal_hit)))
    else $error("coalescing flag stayed after last acknowledge");

  a_one_bit_mode: assert property (
    one_bit && !wr_ctrl |=> (coal_pend_q <= 4'h1) && (dly_pend_q <= 4'h1))
    else $error("pending count exceeds one in one-bit mode");

  a_fault_sticky: assert property (
    rd_fault_q && wr_irq |=> rd_fault_q [*2])
    else $error("read fault flag cleared without reset");

  a_fault_freeze: assert property (
    bus_write_fault |=> stream_freeze && wr_fault_q)
    else $error("write fault did not freeze stream");

  a_select_source: assert property (
    coal_en && !ioe_sel && !eop_event && !load_req |=>
      coal_cnt_q == $past(coal_cnt_q))
    else $error("coalescing counter moved without selected event");

endmodule // tx_dma_irq_coalescing

// ===== tb/cpu_irq_model.sv
// Processor side model that watches the channel interrupt line.
module cpu_irq_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tx_irq,
  output int irq_edges
);
  timeunit 1ns;
  timeprecision 1ps;
  logic irq_q;
  // ==========================================================================
  // Edge counter
  // ==========================================================================
  // A level interrupt is taken once per rising edge, as a core would.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
      irq_edges <= 0;
    end else begin
      irq_q <= tx_irq;
      if (tx_irq && !irq_q) begin
        irq_edges <= irq_edges + 1;
      end
    end
  end
endmodule // cpu_irq_model

// ===== tb/tb_tx_dma_irq_coalescing.sv
// Self-checking testbench for the transmit channel interrupt block.
module tb_tx_dma_irq_coalescing import tx_irq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, soft_reset, dcr_read, dcr_write, dcr_ack;
  logic delay_run, tx_irq, stream_freeze;
  logic [9:0] dcr_addr;
  logic [31:0] dcr_wdata, dcr_rdata, q;
  logic [5:0] ev;
  int irq_edges, err_count, num_checks;
  tx_dma_irq_coalescing i_tx_dma_irq_coalescing (
    .clk(clk), .reset_n(reset_n), .soft_reset(soft_reset),
    .dcr_addr(dcr_addr), .dcr_read(dcr_read), .dcr_write(dcr_write),
    .dcr_wdata(dcr_wdata), .dcr_rdata(dcr_rdata), .dcr_ack(dcr_ack),
    .eop_event(ev[0]), .ioe_event(ev[1]), .error_event(ev[2]),
    .bus_read_fault(ev[3]), .bus_write_fault(ev[4]), .delay_tick(ev[5]),
    .delay_run(delay_run), .tx_irq(tx_irq), .stream_freeze(stream_freeze)
  );
  cpu_irq_model i_cpu_irq_model (
    .clk(clk), .reset_n(reset_n), .tx_irq(tx_irq), .irq_edges(irq_edges)
  );
  // ==========================================================================
  // Access and check tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
      err_count++;
    end
  endtask
  // A request is a one-cycle pulse; holding it longer would repeat the access.
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    dcr_addr <= a;
    dcr_write <= w;
    dcr_read <= !w;
    dcr_wdata <= d;
    @(posedge clk);
    dcr_write <= 1'b0;
    dcr_read <= 1'b0;
    @(posedge clk);
    chk({31'h0, dcr_ack}, 32'h1);
    q = dcr_rdata;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask
  // Each event is a one-cycle pulse followed by an idle cycle.
  task automatic fire(input logic [5:0] m, input int n);
    repeat (n) begin
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 6'h00;
    end
  endtask
  task automatic chk_irq(input logic exp);
    #1;
    chk({31'h0, tx_irq}, {31'h0, exp});
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================================
  // Clock and watchdog
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (6000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    err_count = 0;
    num_checks = 0;
    reset_n = 1'b0;
    soft_reset = 1'b0;
    dcr_read = 1'b0;
    dcr_write = 1'b0;
    dcr_addr = 10'h000;
    dcr_wdata = 32'h0000_0000;
    ev = 6'h00;
    delay_run = 1'b0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    rd(CTRL_ADDR, CFG_DEFAULT);
    rd(IRQ_ADDR, 32'h0000_0000);
    rd(10'h087, 32'h0000_0000);
    wr(10'h087, 32'hffff_ffff);
    rd(CTRL_ADDR, CFG_DEFAULT);
    done("reset");
    wr(CTRL_ADDR, 32'h0000_0084);
    fire(6'h05, 1);
    chk_irq(1'b1);
    rd(IRQ_ADDR, 32'h0000_0004);
    wr(IRQ_ADDR, 32'h0000_0004);
    chk_irq(1'b0);
    rd(IRQ_ADDR, 32'h0000_0000);
    wr(CTRL_ADDR, 32'h0000_0004);
    fire(6'h04, 1);
    chk_irq(1'b0);
    rd(IRQ_ADDR, 32'h0000_0004);
    wr(IRQ_ADDR, 32'h0000_0004);
    done("error");
    wr(CTRL_ADDR, 32'h0002_0181);
    rd(CTRL_ADDR, 32'h0002_0081);
    rd(IRQ_ADDR, 32'h0002_0000);
    fire(6'h06, 2);
    rd(IRQ_ADDR, 32'h0002_0000);
    fire(6'h01, 1);
    rd(IRQ_ADDR, 32'h0001_0000);
    fire(6'h01, 1);
    chk_irq(1'b1);
    rd(IRQ_ADDR, 32'h0002_0401);
    wr(IRQ_ADDR, 32'h0000_0001);
    chk_irq(1'b0);
    rd(IRQ_ADDR, 32'h0002_0000);
    done("coalesce eop");
    wr(CTRL_ADDR, 32'h0002_0281);
    fire(6'h02, 2);
    rd(IRQ_ADDR, 32'h0002_0401);
    fire(6'h01, 2);
    rd(IRQ_ADDR, 32'h0002_0401);
    fire(6'h02, 2);
    rd(IRQ_ADDR, 32'h0002_0801);
    wr(IRQ_ADDR, 32'h0000_0001);
    rd(IRQ_ADDR, 32'h0002_0401);
    wr(IRQ_ADDR, 32'h0000_0001);
    rd(IRQ_ADDR, 32'h0002_0000);
    done("coalesce ioe");
    wr(CTRL_ADDR, 32'h0001_0781);
    fire(6'h02, 3);
    rd(IRQ_ADDR, 32'h0001_0401);
    wr(IRQ_ADDR, 32'h0000_0001);
    rd(IRQ_ADDR, 32'h0001_0000);
    done("one bit");
    wr(CTRL_ADDR, 32'h0201_0082);
    delay_run <= 1'b1;
    fire(6'h20, 1);
    rd(IRQ_ADDR, 32'h0101_0000);
    fire(6'h20, 1);
    rd(IRQ_ADDR, 32'h0201_0000);
    fire(6'h20, 1);
    chk_irq(1'b1);
    rd(IRQ_ADDR, 32'h0001_0102);
    wr(IRQ_ADDR, 32'h0000_0002);
    rd(IRQ_ADDR, 32'h0001_0000);
    done("delay");
    fire(6'h10, 1);
    #1;
    chk({31'h0, stream_freeze}, 32'h1);
    wr(IRQ_ADDR, 32'h0000_0018);
    rd(IRQ_ADDR, 32'h0001_0008);
    fire(6'h08, 1);
    wr(IRQ_ADDR, 32'h0000_0018);
    rd(IRQ_ADDR, 32'h0001_0018);
    chk_irq(1'b0);
    @(posedge clk);
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    rd(IRQ_ADDR, 32'h0000_0000);
    rd(CTRL_ADDR, CFG_DEFAULT);
    chk({31'h0, stream_freeze}, 32'h0);
    done("faults");
    chk(irq_edges, 32'h5);
    tally_and_finish();
  end
endmodule // tb_tx_dma_irq_coalescing
